// ===== include/ris_pkg.sv
// Purpose: Constants and types for the reset initialisation sequencer.
// Assumes: One 10 MHz reference clock; sync-clock periods are counted as ticks.
// Notes: Tick counts below are in sync-clock periods unless named as cycles.
// Contract
// R1: Board holds hard reset low 32 sync periods to start the reset flow.
// R2: Agent mode: power-on reset held 32 sync periods with bus clock running.
// R3: Own hard reset asserted 512 sync periods; 16 periods between negations.
// R4: Host mode: config pins valid 4 primary-clock periods before power-on release.
// R5: Agent mode: config pins valid 4 sync periods before power-on release.
// R6: Config pins held until hard reset negates; hold after negation is zero.
// R7: Hard reset asserted releases every shared config pin promptly.
// R8: Functional drive on shared pins starts at least 1 sync period after negation.
// R9: Config set is 4-bit boot source, bus mux select, clock divide select.
// R10: Host mode sync period comes from primary clock scaled by divide select.
// R11: PLL lock reached within 100 us after reset.
// R12: Hard and soft reset pins driven low or released only; power-on is input.
// R13: Host mode uses primary clock, agent mode uses the bus clock.
// R14: Config latched at power-on release and kept until next power-on reset.
package ris_pkg;

  localparam int RIS_CLK_MHZ = 10;
  localparam int RIS_BOOT_W = 4;
  localparam int RIS_CFG_W = RIS_BOOT_W + 2;
  localparam int RIS_HRST_ASSERT_TICKS = 512;
  localparam int RIS_HRST_GAP_TICKS = 16;
  localparam int RIS_EXT_HRST_TICKS = 32;
  localparam int RIS_FUNC_DELAY_TICKS = 1;
  localparam int RIS_PLL_LOCK_US = 100;
  localparam int RIS_PLL_LOCK_CYCLES = RIS_PLL_LOCK_US * RIS_CLK_MHZ;
  localparam int RIS_SYNC_DIV_LO = 2;
  localparam int RIS_SYNC_DIV_HI = 4;
  localparam int RIS_CNT_W = 10;
  localparam int RIS_GAP_W = 5;
  localparam int RIS_DIV_W = 2;
  localparam int RIS_LOCK_W = 10;
  localparam int RIS_DIV_BIT = 0;
  localparam int RIS_MUX_BIT = 1;
  localparam int RIS_BOOT_LSB = 2;
  localparam int RIS_LOCK_LEAD = 2;

  typedef enum logic [1:0] {
    RIS_ST_POR = 2'b00,
    RIS_ST_ASSERT = 2'b01,
    RIS_ST_RELEASE = 2'b10,
    RIS_ST_RUN = 2'b11
  } ris_state_type;

endpackage

// ===== logic/ris_sequencer.sv
// Purpose: Reset flow, config strap latch and shared-pin hand-over.
// Assumes: All pins asynchronous to ref_clk_i; two-flop synchronisers on each.
// Notes: Open-drain pins use an enable that is low while the pin is pulled low.
`timescale 1ns/1ps
module ris_sequencer #(
  parameter int ASSERT_TICKS = ris_pkg::RIS_HRST_ASSERT_TICKS,
  parameter int GAP_TICKS = ris_pkg::RIS_HRST_GAP_TICKS,
  parameter int EXT_TICKS = ris_pkg::RIS_EXT_HRST_TICKS
) (
  input wire logic ref_clk_i, // 10 MHz reference
  input wire logic reset_i, // Async reset, active high
  input wire logic power_on_reset_n_i, // Power-on reset pin
  input wire logic hard_reset_n_i, // Hard reset pin level
  output logic hard_reset_n_o, // Hard reset drive value
  output logic hard_reset_n_oe_o, // Low pulls hard reset low
  output logic soft_reset_n_o, // Soft reset drive value
  output logic soft_reset_n_oe_o, // Low pulls soft reset low
  input wire logic host_mode_i, // High selects host mode
  input wire logic pci_clk_i, // Bus clock, agent mode
  input wire logic [ris_pkg::RIS_BOOT_W-1:0] boot_source_select_i, // Boot source straps
  input wire logic local_bus_mux_select_i, // Bus mux strap
  input wire logic input_clock_divide_select_i, // Clock divide strap
  input wire logic [ris_pkg::RIS_CFG_W-1:0] func_data_i, // Functional data for shared pins
  output logic [ris_pkg::RIS_CFG_W-1:0] shared_pin_o, // Shared pin drive values
  output logic [ris_pkg::RIS_CFG_W-1:0] shared_pin_oe_o, // Low drives shared pins
  output logic [ris_pkg::RIS_BOOT_W-1:0] boot_source_select_o, // Latched boot source
  output logic local_bus_mux_select_o, // Latched bus mux select
  output logic input_clock_divide_select_o, // Latched divide select
  output logic host_mode_o, // Latched host mode
  output logic sync_tick_o, // One pulse per sync period
  output logic pll_lock_o // PLL lock indication
);
  import ris_pkg::*;

  if (ASSERT_TICKS < 1 || ASSERT_TICKS >= (1 << RIS_CNT_W) - 1 || GAP_TICKS < 1 ||
      GAP_TICKS >= (1 << RIS_GAP_W) || EXT_TICKS < 1 || EXT_TICKS >= (1 << RIS_CNT_W)) begin
    $error("ris_sequencer: tick counts out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  logic por_s1_r, por_s2_r, hrst_s1_r, hrst_s2_r, host_s1_r, host_s2_r;
  logic pci_s1_r, pci_s2_r, pci_s3_r;
  logic [RIS_CFG_W-1:0] cfg_s1_r, cfg_s2_r;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      por_s1_r <= 1'b0;
      por_s2_r <= 1'b0;
      hrst_s1_r <= 1'b0;
      hrst_s2_r <= 1'b0;
      host_s1_r <= 1'b0;
      host_s2_r <= 1'b0;
      pci_s1_r <= 1'b0;
      pci_s2_r <= 1'b0;
      pci_s3_r <= 1'b0;
      cfg_s1_r <= '0;
      cfg_s2_r <= '0;
    end else begin
      por_s1_r <= power_on_reset_n_i;
      por_s2_r <= por_s1_r;
      hrst_s1_r <= hard_reset_n_i;
      hrst_s2_r <= hrst_s1_r;
      host_s1_r <= host_mode_i;
      host_s2_r <= host_s1_r;
      pci_s1_r <= pci_clk_i;
      pci_s2_r <= pci_s1_r;
      pci_s3_r <= pci_s2_r;
      cfg_s1_r <= {boot_source_select_i, local_bus_mux_select_i, input_clock_divide_select_i};
      cfg_s2_r <= cfg_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  ris_state_type state_r, state_nxt;
  logic [RIS_CNT_W-1:0] cnt_r, ext_cnt_r;
  logic [RIS_GAP_W-1:0] gap_r;
  logic [RIS_CFG_W-1:0] cfg_r;
  logic host_r, tick_r;
  logic [RIS_DIV_W-1:0] div_cnt_r;
  logic [RIS_LOCK_W-1:0] lock_cnt_r;
  logic drive_en;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RIS_ST_POR: begin
        if (por_s2_r) state_nxt = RIS_ST_ASSERT;
      end
      RIS_ST_ASSERT: begin
        if (cnt_r > RIS_CNT_W'(ASSERT_TICKS) && gap_r >= RIS_GAP_W'(GAP_TICKS)) begin // R3
          state_nxt = RIS_ST_RELEASE;
        end
      end
      RIS_ST_RELEASE: begin
        if (cnt_r > RIS_CNT_W'(RIS_FUNC_DELAY_TICKS)) state_nxt = RIS_ST_RUN; // R8
      end
      RIS_ST_RUN: begin
        if (ext_cnt_r >= RIS_CNT_W'(EXT_TICKS)) state_nxt = RIS_ST_ASSERT; // R1
      end
      default: state_nxt = RIS_ST_POR;
    endcase
    if (!por_s2_r) state_nxt = RIS_ST_POR;
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) state_r <= RIS_ST_POR;
    else state_r <= state_nxt;
  end

  // Sync periods counted while asserting or waiting after release
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) cnt_r <= '0;
    else if (state_nxt != state_r) cnt_r <= '0;
    else if (tick_r && cnt_r != '1) cnt_r <= cnt_r + 1'b1;
  end

  // Sync periods since the last negation of our own hard reset
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) gap_r <= RIS_GAP_W'(GAP_TICKS);
    else if (state_r == RIS_ST_ASSERT && state_nxt == RIS_ST_RELEASE) gap_r <= '0; // R3
    else if (tick_r && gap_r < RIS_GAP_W'(GAP_TICKS)) gap_r <= gap_r + 1'b1;
  end

  // External hard reset low time, in sync periods
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) ext_cnt_r <= '0;
    else if (hrst_s2_r || state_r != RIS_ST_RUN) ext_cnt_r <= '0;
    else if (tick_r && ext_cnt_r != '1) ext_cnt_r <= ext_cnt_r + 1'b1; // R1
  end

  // Straps follow the pins during power-on reset, frozen at its release
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_r <= '0;
      host_r <= 1'b0;
    end else if (state_r == RIS_ST_POR) begin
      cfg_r <= cfg_s2_r; // R14 R9 R5 R4
      host_r <= host_s2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sync clock tick
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) div_cnt_r <= '0;
    else if (!host_r) div_cnt_r <= '0;
    else if (div_cnt_r >=
             RIS_DIV_W'((cfg_r[RIS_DIV_BIT] ? RIS_SYNC_DIV_HI : RIS_SYNC_DIV_LO) - 1)) begin
      div_cnt_r <= '0; // R10
    end else div_cnt_r <= div_cnt_r + 1'b1;
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) tick_r <= 1'b0;
    else if (host_r) tick_r <= (div_cnt_r == '0); // R13 R10
    else tick_r <= pci_s2_r & ~pci_s3_r; // R13 R2
  end

  ////////////////////////////////////////////////////////////////////////////
  // PLL lock timer from power-on release
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) lock_cnt_r <= '0;
    else if (state_r == RIS_ST_POR) lock_cnt_r <= '0;
    else if (lock_cnt_r < RIS_LOCK_W'(RIS_PLL_LOCK_CYCLES)) lock_cnt_r <= lock_cnt_r + 1'b1;
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) pll_lock_o <= 1'b0;
    else pll_lock_o <= state_r != RIS_ST_POR &&
                       lock_cnt_r >= RIS_LOCK_W'(RIS_PLL_LOCK_CYCLES - RIS_LOCK_LEAD); // R11
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins
  assign drive_en = state_nxt == RIS_ST_RUN && hrst_s2_r;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      hard_reset_n_o <= 1'b0;
      hard_reset_n_oe_o <= 1'b0;
      soft_reset_n_o <= 1'b0;
      soft_reset_n_oe_o <= 1'b1;
    end else begin
      hard_reset_n_o <= 1'b0; // R12
      hard_reset_n_oe_o <= !(state_nxt == RIS_ST_POR || state_nxt == RIS_ST_ASSERT); // R3
      soft_reset_n_o <= 1'b0; // R12
      soft_reset_n_oe_o <= 1'b1;
    end
  end

  for (genvar i = 0; i < RIS_CFG_W; i++) begin : g_shared
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
        shared_pin_o[i] <= 1'b0;
        shared_pin_oe_o[i] <= 1'b1;
      end else begin
        shared_pin_o[i] <= func_data_i[i];
        shared_pin_oe_o[i] <= !drive_en; // R7 R8 R6
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      boot_source_select_o <= '0;
      local_bus_mux_select_o <= 1'b0;
      input_clock_divide_select_o <= 1'b0;
      host_mode_o <= 1'b0;
      sync_tick_o <= 1'b0;
    end else begin
      boot_source_select_o <= cfg_r[RIS_CFG_W-1:RIS_BOOT_LSB]; // R14
      local_bus_mux_select_o <= cfg_r[RIS_MUX_BIT];
      input_clock_divide_select_o <= cfg_r[RIS_DIV_BIT];
      host_mode_o <= host_r;
      sync_tick_o <= tick_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  localparam int LOCK_WAIT = 1000;

  // Sync periods seen while our own pull is on, kept apart from the state counter
  logic [RIS_CNT_W-1:0] low_ticks_r;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) low_ticks_r <= '0;
    else if (hard_reset_n_oe_o) low_ticks_r <= '0;
    else if (tick_r && low_ticks_r != '1) low_ticks_r <= low_ticks_r + 1'b1;
  end

  chk_hrst_width: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R3
    $rose(hard_reset_n_oe_o) |-> $past(low_ticks_r) >= RIS_CNT_W'(ASSERT_TICKS))
    else $error("hard reset released early");
  chk_negation_gap: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R3
    $rose(hard_reset_n_oe_o) |-> $past(gap_r) >= RIS_GAP_W'(GAP_TICKS))
    else $error("negations too close");
  chk_cfg_pins_off: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R7
    !hard_reset_n_oe_o |-> &shared_pin_oe_o) else $error("shared pin driven in reset");
  chk_func_late: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R8
    $fell(shared_pin_oe_o[0]) |-> $past(hard_reset_n_oe_o, 2))
    else $error("functional drive too soon");
  chk_never_high: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R12
    !hard_reset_n_o && !soft_reset_n_o && soft_reset_n_oe_o)
    else $error("reset pin driven high");
  chk_cfg_frozen: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R14
    (state_r != RIS_ST_POR && $past(state_r) != RIS_ST_POR) |-> $stable(cfg_r))
    else $error("straps changed after latch");
  chk_pll_lock: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R11
    (state_r == RIS_ST_POR && state_nxt != RIS_ST_POR) |->
      ##[1:LOCK_WAIT] pll_lock_o) else $error("pll lock late");
  chk_host_tick: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R10
    (host_r && !cfg_r[RIS_DIV_BIT] && tick_r && state_r != RIS_ST_POR) |-> ##2 tick_r)
    else $error("host sync period wrong");
  chk_agent_tick: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R13
    (!host_r && pci_s2_r && !pci_s3_r) |=> tick_r) else $error("agent tick missed");
  chk_ext_reset: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R1
    (state_r == RIS_ST_RUN && ext_cnt_r >= RIS_CNT_W'(EXT_TICKS) && por_s2_r) |=>
      state_r == RIS_ST_ASSERT) else $error("external hard reset ignored");

  cov_full_boot: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    $rose(state_r == RIS_ST_RUN));
  cov_ext_reset: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    state_r == RIS_ST_RUN ##1 state_r == RIS_ST_ASSERT);
  cov_host_div: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    host_r && cfg_r[RIS_DIV_BIT] && tick_r);
  cov_agent_run: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    !host_r && state_r == RIS_ST_RUN);
endmodule

// ===== tb/ris_board.sv
// Purpose: Board supervisor and strap driver facing the sequencer.
// Assumes: Hard reset wire has a pull-up; strap lines float once released.
// Notes: Released straps show the inverse of the strapped value.
`timescale 1ns/1ps
module ris_board (
  input wire logic ref_clk_i, // Reference clock
  input wire logic por_req_i, // Bench asks for power-on reset
  input wire logic ext_hrst_i, // Bench pulls hard reset low
  input wire logic [5:0] strap_i, // Strap values {boot,mux,div}
  input wire logic hard_reset_n_oe_i, // Sequencer pull, low pulls
  output logic power_on_reset_n_o, // Power-on reset pin
  output logic hard_reset_n_o, // Hard reset wire level
  output logic [5:0] strap_o, // Strap pin levels
  output logic pci_clk_o // Free-running bus clock
);
  logic [8:0] por_cnt_r = 9'h000;
  logic held_r = 1'b1;
  logic [2:0] pci_cnt_r = 3'h0;
  initial power_on_reset_n_o = 1'b0;
  ////////////////////////////////////////////////////////////////
  // Power-on reset held 511 cycles, over 32 bus clock periods
  always @(posedge ref_clk_i) begin
    if (por_req_i) begin
      por_cnt_r <= por_cnt_r + {8'h00, por_cnt_r != 9'h1ff};
      power_on_reset_n_o <= 1'b0;
    end else if (por_cnt_r == 9'h1ff) begin
      power_on_reset_n_o <= 1'b1;
      por_cnt_r <= 9'h000;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (!power_on_reset_n_o) begin
      held_r <= 1'b1;
    end else if (hard_reset_n_o) begin
      held_r <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    pci_cnt_r <= pci_cnt_r + 3'h1;
  end
  ////////////////////////////////////////////////////////////////
  assign strap_o = held_r ? strap_i : ~strap_i;
  assign hard_reset_n_o = hard_reset_n_oe_i & ~ext_hrst_i;
  assign pci_clk_o = pci_cnt_r[2];
endmodule

// ===== tb/reset_init_sequencer_test.sv
// Purpose: Self-checking bench for the reset sequencer.
// Assumes: Shortened counts 8, 4 and 4 ticks.
// Notes: Bus clock period is 8 reference cycles.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module reset_init_sequencer_test;
  localparam int AT = 8;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic por_req = 1'b1;
  logic ext_hrst = 1'b0;
  logic host_mode = 1'b1;
  logic [5:0] straps = 6'h2a;
  logic [5:0] func_data = 6'h00;
  logic power_on_reset_n, hard_reset_n, pci_clk, hard_reset_n_o, hard_reset_n_oe_o;
  logic soft_reset_n_o, soft_reset_n_oe_o, local_bus_mux_select_o, input_clock_divide_select_o;
  logic host_mode_o, sync_tick_o, pll_lock_o;
  logic [5:0] strap_pins, shared_pin_o, shared_pin_oe_o;
  logic [3:0] boot_source_select_o;
  int err_total = 0;
  int n_checks = 0;
  time last_neg = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  ris_board i_ris_board (.ref_clk_i(ref_clk_i), .por_req_i(por_req), .ext_hrst_i(ext_hrst),
    .strap_i(straps), .hard_reset_n_oe_i(hard_reset_n_oe_o),
    .power_on_reset_n_o(power_on_reset_n), .hard_reset_n_o(hard_reset_n),
    .strap_o(strap_pins), .pci_clk_o(pci_clk));
  ris_sequencer #(.ASSERT_TICKS(AT), .GAP_TICKS(4), .EXT_TICKS(4)) i_ris_sequencer (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .power_on_reset_n_i(power_on_reset_n),
    .hard_reset_n_i(hard_reset_n), .hard_reset_n_o(hard_reset_n_o),
    .hard_reset_n_oe_o(hard_reset_n_oe_o), .soft_reset_n_o(soft_reset_n_o),
    .soft_reset_n_oe_o(soft_reset_n_oe_o), .host_mode_i(host_mode), .pci_clk_i(pci_clk),
    .boot_source_select_i(strap_pins[5:2]), .local_bus_mux_select_i(strap_pins[1]),
    .input_clock_divide_select_i(strap_pins[0]), .func_data_i(func_data),
    .shared_pin_o(shared_pin_o), .shared_pin_oe_o(shared_pin_oe_o),
    .boot_source_select_o(boot_source_select_o), .local_bus_mux_select_o(local_bus_mux_select_o),
    .input_clock_divide_select_o(input_clock_divide_select_o), .host_mode_o(host_mode_o),
    .sync_tick_o(sync_tick_o), .pll_lock_o(pll_lock_o));
  ////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (err_total == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic in_reset();
    repeat (2) @(posedge ref_clk_i);
    #10;
    `CHK("oe_in_reset", 7'h7e, {shared_pin_oe_o, hard_reset_n_oe_o})
    `CHK("soft_and_drive", 3'h4, {soft_reset_n_oe_o, soft_reset_n_o, hard_reset_n_o})
    @(posedge ref_clk_i);
    reset_i <= 1'b0;
  endtask
  task automatic boot(input logic host, input logic [5:0] st);
    int n;
    int per;
    time t0;
    per = host ? (2 << st[0]) : 8;
    @(posedge ref_clk_i);
    por_req <= 1'b1;
    host_mode <= host;
    straps <= st;
    func_data <= ~st;
    repeat (10) @(negedge ref_clk_i);
    `CHK("por_drives_low", 1'b0, hard_reset_n_oe_o)
    repeat (520) @(posedge ref_clk_i);
    por_req <= 1'b0;
    @(posedge power_on_reset_n);
    t0 = $time;
    n = 0;
    while (hard_reset_n_oe_o !== 1'b1 && n < 2000) begin
      @(negedge ref_clk_i);
      n++;
    end
    last_neg = $time;
    `CHK("assert_len", 1'b1, n >= per * AT && n <= per * (AT + 4) + 8)
    n = 0;
    while (shared_pin_oe_o !== 6'h00 && n < 200) begin
      @(negedge ref_clk_i);
      n++;
    end
    `CHK("drive_delay", 1'b1, n >= per && n <= 4 * per)
    `CHK("latched", {st, host}, {boot_source_select_o, local_bus_mux_select_o,
      input_clock_divide_select_o, host_mode_o})
    repeat (3) @(negedge ref_clk_i);
    `CHK("func_out", ~st, shared_pin_o)
    n = 0;
    while (sync_tick_o !== 1'b1 && n < 40) begin
      @(negedge ref_clk_i);
      n++;
    end
    n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (sync_tick_o !== 1'b1 && n < 40);
    `CHK("tick_period", per, n)
    n = 0;
    while (pll_lock_o !== 1'b1 && n < 1200) begin
      @(negedge ref_clk_i);
      n++;
    end
    `CHK("pll_lock", 1'b1, pll_lock_o === 1'b1 &&
      ($time - t0) <= (ris_pkg::RIS_PLL_LOCK_CYCLES + 4) * 100)
  endtask
  task automatic ext_hard_reset();
    int n;
    @(posedge ref_clk_i);
    ext_hrst <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #10;
    `CHK("pins_off", 6'h3f, shared_pin_oe_o)
    @(posedge ref_clk_i);
    ext_hrst <= 1'b0;
    repeat (6) @(negedge ref_clk_i);
    `CHK("short_pulse", 1'b1, hard_reset_n_oe_o)
    @(posedge ref_clk_i);
    ext_hrst <= 1'b1;
    n = 0;
    while (hard_reset_n_oe_o !== 1'b0 && n < 40) begin
      @(negedge ref_clk_i);
      n++;
    end
    @(posedge ref_clk_i);
    ext_hrst <= 1'b0;
    n = 0;
    while (hard_reset_n_oe_o !== 1'b1 && n < 200) begin
      @(negedge ref_clk_i);
      n++;
    end
    `CHK("reassert_len", 1'b1, n >= 2 * AT && n < 200)
    `CHK("neg_gap", 1'b1, ($time - last_neg) >= 4 * 2 * 100)
    `CHK("straps_kept", 4'ha, boot_source_select_o)
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_total++;
    finish_test();
  end
  initial begin
    in_reset();
    boot(1'b1, 6'h2a);
    ext_hard_reset();
    boot(1'b1, 6'h15);
    boot(1'b0, 6'h33);
    finish_test();
  end
endmodule
